/* File: rtl/rtccs_pkg.sv */
/*
  rtccs_pkg: offsets, field positions, reset values and timing counts for the
  calendar control/status flag block.
  assumes: avalon-mm word addressing of byte offsets, 32-bit data.
*/
package rtccs_pkg;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL      = 8'h08;
  localparam logic [7:0]  OFS_STS       = 8'h0c;
  localparam logic [7:0]  OFS_SHIFT     = 8'h28;
  localparam logic [7:0]  OFS_WAKE_CFG  = 8'h14;
  localparam logic [7:0]  OFS_IRQ_STS   = 8'h40;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h44;
  localparam logic [7:0]  OFS_WPROT     = 8'h24;
  localparam logic [7:0]  OFS_CAL_VIEW  = 8'h48;
  // control field positions
  localparam int CTRL_SHADOW_BYP  = 5;
  localparam int CTRL_ALARM_EN    = 8;
  localparam int CTRL_WAKE_EN     = 10;
  localparam int CTRL_SUMMER      = 16;
  localparam int CTRL_WINTER      = 17;
  localparam int CTRL_BACKUP      = 18;
  localparam int CTRL_CAL_SEL     = 19;
  localparam int CTRL_POL         = 20;
  localparam int CTRL_ROUTE_LO    = 21;
  localparam int CTRL_CAL_EN      = 23;
  localparam logic [31:0] CTRL_WMASK = 32'h00fc_0520;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // status field positions
  localparam int STS_ALARM_WR   = 0;
  localparam int STS_WAKE_WR    = 2;
  localparam int STS_SHIFT_PEND = 3;
  localparam int STS_CAL_SET    = 4;
  localparam int STS_SYNCED     = 5;
  localparam int STS_INIT_RDY   = 6;
  localparam int STS_INIT_REQ   = 7;
  localparam logic [31:0] STS_RESET = 32'h0000_0007;
  // route encodings
  localparam logic [1:0] ROUTE_OFF   = 2'h0;
  localparam logic [1:0] ROUTE_ALARM = 2'h1;
  localparam logic [1:0] ROUTE_WAKE  = 2'h3;
  // write-protection unlock key pair
  localparam logic [7:0] WP_KEY1 = 8'hca;
  localparam logic [7:0] WP_KEY2 = 8'h53;
  // timing
  localparam int KCLK_HZ         = 32768;
  localparam int WAKE_WR_DELAY   = 2;
  localparam int SHADOW_PERIOD   = 2;
  localparam int INIT_RDY_DELAY  = 2;
  localparam int SHIFT_DONE_CYC  = 3;
  localparam int TAP512_HALF_CYC = 32;
  localparam logic [6:0]  ASYNC_DIV_DEF = 7'h7f;
  localparam logic [14:0] SYNC_DIV_DEF  = 15'h00ff;
  // interrupt bits
  localparam int IRQ_SYNC  = 0;
  localparam int IRQ_ALARM = 1;
  localparam int IRQ_WAKE  = 2;
  localparam int IRQ_SHIFT = 3;
endpackage

/* File: rtl/rtccs_top.sv */
/*
  rtccs_top: calendar control bits, status flags, dst hour adjust,
  calibration and alarm pin outputs, avalon-mm slave with interrupt.
  assumes: one clock (the kernel clock), synchronous active-high reset,
  alarm/wakeup events and year value arrive from the same clock domain.
*/
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
module rtccs_top
  import rtccs_pkg::*;
#(
  parameter int ASYNC_DIV = 127,
  parameter int SYNC_DIV  = 255
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // avalon-mm slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // calendar side
  input  wire logic [7:0]  year_field,
  input  wire logic        alarm_a_match_flag,
  input  wire logic        wakeup_expired_flag,
  input  wire logic        alarm_value_change,
  // pins and adjust strobes
  output logic             calibration_pin,
  output logic             alarm_pin,
  output logic             hour_inc_pulse,
  output logic             hour_dec_pulse,
  output logic             irq
);

  logic [31:0] ctrl_reg;
  logic [31:0] sts_reg;
  logic [3:0]  irq_sts_reg;
  logic [3:0]  irq_mask_reg;
  logic [1:0]  wp_state_reg;
  logic        ack_reg;
  logic [5:0]  hour_reg;
  logic [5:0]  hour_live_reg;
  logic [5:0]  hour_shadow_reg;
  logic [6:0]  adiv_reg;
  logic [14:0] sdiv_reg;
  logic        tap512_reg;
  logic        tap1_reg;
  logic [1:0]  wake_cnt_reg;
  logic        shadow_tick_reg;
  logic [1:0]  shift_cnt_reg;
  logic [1:0]  init_cnt_reg;
  logic        alarm_en_q_reg;

  logic        unlocked;
  logic        acc;
  logic        wr_hit;
  logic [31:0] wmask;
  logic [31:0] wdata_m;
  logic        init_mode;
  logic        sync_evt;
  logic        shift_evt;
  logic        shift_done;
  logic        alarm_sel;

  assign unlocked  = (wp_state_reg == 2'h2);
  assign acc       = clk_en && (read || write) && !ack_reg;
  // writes commit only on the edge that completes the transfer
  assign wr_hit    = clk_en && write && ack_reg;
  assign wmask     = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
  assign wdata_m   = writedata & wmask;
  assign init_mode = sts_reg[STS_INIT_REQ];
  assign shift_evt = wr_hit && address == OFS_SHIFT;
  assign shift_done = sts_reg[STS_SHIFT_PEND] && shift_cnt_reg == 2'(SHIFT_DONE_CYC - 1);
  assign sync_evt  = shadow_tick_reg && !init_mode && !sts_reg[STS_SHIFT_PEND] && !ctrl_reg[CTRL_SHADOW_BYP];

  // bus handshake: one wait cycle, answer on the second edge
  always_ff @(posedge clock) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else if (clk_en) begin
      ack_reg <= (read || write) && !ack_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else if (clk_en) begin
      waitrequest <= !((read || write) && !ack_reg);
    end
  end

  // write protection key sequence; any other value relocks
  always_ff @(posedge clock) begin
    if (rst) begin
      wp_state_reg <= 2'h0;
    end else if (wr_hit && address == OFS_WPROT) begin
      if (writedata[7:0] == WP_KEY1) begin
        wp_state_reg <= 2'h1;
      end else if (writedata[7:0] == WP_KEY2 && wp_state_reg == 2'h1) begin
        wp_state_reg <= 2'h2;
      end else begin
        wp_state_reg <= 2'h0;
      end
    end
  end

  // control register; dst request bits never stored
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_hit && address == OFS_CTRL && unlocked) begin
      ctrl_reg <= (ctrl_reg & ~(wmask & CTRL_WMASK)) | (wdata_m & CTRL_WMASK);
    end
  end

  // dst adjust strobes, honoured only in free-run mode
  always_ff @(posedge clock) begin
    if (rst) begin
      hour_inc_pulse <= 1'b0;
      hour_dec_pulse <= 1'b0;
    end else if (clk_en) begin
      hour_inc_pulse <= wr_hit && address == OFS_CTRL && unlocked && !init_mode
                        && wdata_m[CTRL_SUMMER];
      hour_dec_pulse <= wr_hit && address == OFS_CTRL && unlocked && !init_mode
                        && wdata_m[CTRL_WINTER] && hour_live_reg != 6'h00;
    end
  end

  // local hour counter so the retard check and shadows have a real value
  always_ff @(posedge clock) begin
    if (rst) begin
      hour_live_reg <= 6'h00;
    end else if (clk_en && !init_mode) begin
      if (hour_inc_pulse) begin
        hour_live_reg <= (hour_live_reg == 6'd23) ? 6'h00 : hour_live_reg + 6'h01;
      end else if (hour_dec_pulse) begin
        hour_live_reg <= hour_live_reg - 6'h01;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      hour_reg <= 6'h00;
    end else if (clk_en) begin
      hour_reg <= hour_live_reg;
    end
  end

  // shadow refresh every two cycles
  always_ff @(posedge clock) begin
    if (rst) begin
      shadow_tick_reg <= 1'b0;
      hour_shadow_reg <= 6'h00;
    end else if (clk_en) begin
      shadow_tick_reg <= !shadow_tick_reg;
      if (sync_evt) begin
        hour_shadow_reg <= hour_reg;
      end
    end
  end

  // 512Hz tap: 32-cycle half period; 1Hz tap toggles twice per sync wrap
  always_ff @(posedge clock) begin
    if (rst) begin
      adiv_reg   <= ASYNC_DIV_DEF;
      sdiv_reg   <= SYNC_DIV_DEF;
      tap512_reg <= 1'b0;
      tap1_reg   <= 1'b0;
    end else if (clk_en && !init_mode) begin
      if (adiv_reg == 7'h00) begin
        adiv_reg <= 7'(ASYNC_DIV);
        if (sdiv_reg == 15'h0000) begin
          sdiv_reg <= 15'(SYNC_DIV);
        end else begin
          sdiv_reg <= sdiv_reg - 15'h0001;
        end
        if (sdiv_reg == 15'h0000 || sdiv_reg == 15'((SYNC_DIV + 1) / 2)) begin
          tap1_reg <= !tap1_reg;
        end
      end else begin
        adiv_reg <= adiv_reg - 7'h01;
      end
      if (adiv_reg % 7'(TAP512_HALF_CYC) == 7'h00) begin
        tap512_reg <= !tap512_reg;
      end
    end
  end

  // output pins
  assign alarm_sel = (ctrl_reg[CTRL_ROUTE_LO +: 2] == ROUTE_ALARM) ? alarm_a_match_flag :
                     (ctrl_reg[CTRL_ROUTE_LO +: 2] == ROUTE_WAKE)  ? wakeup_expired_flag : 1'b0;

  always_ff @(posedge clock) begin
    if (rst) begin
      calibration_pin <= 1'b0;
      alarm_pin       <= 1'b0;
    end else if (clk_en) begin
      calibration_pin <= ctrl_reg[CTRL_CAL_EN] &&
                         (ctrl_reg[CTRL_CAL_SEL] ? tap1_reg : tap512_reg);
      alarm_pin       <= ctrl_reg[CTRL_POL] ^ alarm_sel;
    end
  end

  // wakeup write-ok delay counter
  always_ff @(posedge clock) begin
    if (rst) begin
      wake_cnt_reg <= 2'h0;
    end else if (clk_en) begin
      if (ctrl_reg[CTRL_WAKE_EN] == sts_reg[STS_WAKE_WR]) begin
        wake_cnt_reg <= (wake_cnt_reg == 2'(WAKE_WR_DELAY - 1)) ? 2'h0 : wake_cnt_reg + 2'h1;
      end else begin
        wake_cnt_reg <= 2'h0;
      end
    end
  end

  // shift completion and init-ready counters
  always_ff @(posedge clock) begin
    if (rst) begin
      shift_cnt_reg <= 2'h0;
      init_cnt_reg  <= 2'h0;
    end else if (clk_en) begin
      shift_cnt_reg <= sts_reg[STS_SHIFT_PEND] ? shift_cnt_reg + 2'h1 : 2'h0;
      if (!init_mode) begin
        init_cnt_reg <= 2'h0;
      end else if (init_cnt_reg != 2'(INIT_RDY_DELAY)) begin
        init_cnt_reg <= init_cnt_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      alarm_en_q_reg <= 1'b0;
    end else if (clk_en) begin
      alarm_en_q_reg <= ctrl_reg[CTRL_ALARM_EN];
    end
  end

  // status register
  always_ff @(posedge clock) begin
    if (rst) begin
      sts_reg <= STS_RESET;
    end else if (clk_en) begin
      if (wr_hit && address == OFS_STS && unlocked) begin
        sts_reg[STS_INIT_REQ] <= writedata[STS_INIT_REQ];
      end
      if (init_mode) begin
        sts_reg[STS_ALARM_WR] <= 1'b0;
      end else if (!ctrl_reg[CTRL_ALARM_EN] && alarm_value_change) begin
        sts_reg[STS_ALARM_WR] <= 1'b1;
      end
      if (ctrl_reg[CTRL_WAKE_EN] == sts_reg[STS_WAKE_WR] && wake_cnt_reg == 2'(WAKE_WR_DELAY - 1)) begin
        sts_reg[STS_WAKE_WR] <= !ctrl_reg[CTRL_WAKE_EN];
      end
      if (shift_evt) begin
        sts_reg[STS_SHIFT_PEND] <= 1'b1;
      end else if (shift_done) begin
        sts_reg[STS_SHIFT_PEND] <= 1'b0;
      end
      sts_reg[STS_CAL_SET] <= (year_field != 8'h00);
      if (sync_evt) begin
        sts_reg[STS_SYNCED] <= 1'b1;
      end else if (init_mode || sts_reg[STS_SHIFT_PEND] || ctrl_reg[CTRL_SHADOW_BYP]) begin
        sts_reg[STS_SYNCED] <= 1'b0;
      end else if (wr_hit && address == OFS_STS && unlocked && !writedata[STS_SYNCED]) begin
        sts_reg[STS_SYNCED] <= 1'b0;
      end
      sts_reg[STS_INIT_RDY] <= init_mode && init_cnt_reg == 2'(INIT_RDY_DELAY);
      sts_reg[31:8] <= 24'h00_0000;
      sts_reg[1]    <= 1'b0;
    end
  end

  // interrupt status, write one to clear, set wins
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_sts_reg  <= 4'h0;
      irq_mask_reg <= 4'h0;
    end else if (clk_en) begin
      irq_sts_reg <= (irq_sts_reg & ~((wr_hit && address == OFS_IRQ_STS) ? writedata[3:0] : 4'h0))
                     | {shift_done, wakeup_expired_flag, alarm_a_match_flag, sync_evt};
      if (wr_hit && address == OFS_IRQ_MASK) begin
        irq_mask_reg <= writedata[3:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(irq_sts_reg & irq_mask_reg);
    end
  end

  // read mux; calendar view honours shadow bypass
  always_ff @(posedge clock) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (acc && read) begin
      case (address)
        OFS_CTRL:     readdata <= ctrl_reg;
        OFS_STS:      readdata <= sts_reg;
        OFS_IRQ_STS:  readdata <= {28'h000_0000, irq_sts_reg};
        OFS_IRQ_MASK: readdata <= {28'h000_0000, irq_mask_reg};
        OFS_WPROT:    readdata <= {30'h0000_0000, wp_state_reg};
        OFS_CAL_VIEW: readdata <= {26'h000_0000, ctrl_reg[CTRL_SHADOW_BYP] ? hour_live_reg : hour_shadow_reg};
        default:      readdata <= 32'h0000_0000;
      endcase
    end
  end

  // assertions
  property p_sum;
    @(posedge clock) disable iff (rst)
    (wr_hit && address == OFS_CTRL && unlocked && !init_mode && wdata_m[CTRL_SUMMER]) |=> hour_inc_pulse;
  endproperty
  a_sum: assert property (p_sum) else $error("summer request lost");

  property p_win;
    @(posedge clock) disable iff (rst) hour_dec_pulse |-> $past(hour_live_reg) != 6'h00;
  endproperty
  a_win: assert property (p_win) else $error("winter retard at hour zero");

  property p_ctrl_rd;
    @(posedge clock) disable iff (rst) !ctrl_reg[CTRL_WINTER] && !ctrl_reg[CTRL_SUMMER] && ctrl_reg[31:24] == 8'h00;
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control reserved or request bit stored");

  property p_cal_off;
    @(posedge clock) disable iff (rst) clk_en && !ctrl_reg[CTRL_CAL_EN] |=> !calibration_pin;
  endproperty
  a_cal_off: assert property (p_cal_off) else $error("calibration pin active while disabled");

  property p_route_off;
    @(posedge clock) disable iff (rst)
    clk_en && ctrl_reg[CTRL_ROUTE_LO +: 2] == ROUTE_OFF |=> alarm_pin == $past(ctrl_reg[CTRL_POL]);
  endproperty
  a_route_off: assert property (p_route_off) else $error("alarm pin not idle when route off");

  property p_wake;
    @(posedge clock) disable iff (rst || !clk_en)
    $fell(ctrl_reg[CTRL_WAKE_EN]) ##1 !ctrl_reg[CTRL_WAKE_EN] [*2] |-> sts_reg[STS_WAKE_WR];
  endproperty
  a_wake: assert property (p_wake) else $error("wakeup write flag late");

  property p_shift;
    @(posedge clock) disable iff (rst) clk_en && shift_evt |=> sts_reg[STS_SHIFT_PEND];
  endproperty
  a_shift: assert property (p_shift) else $error("shift pending not set");

  property p_init_clr;
    @(posedge clock) disable iff (rst)
    clk_en && init_mode |=> !sts_reg[STS_ALARM_WR] && !sts_reg[STS_SYNCED];
  endproperty
  a_init_clr: assert property (p_init_clr) else $error("flags not cleared in init");

  property p_rdy;
    @(posedge clock) disable iff (rst) sts_reg[STS_INIT_RDY] |-> $past(init_mode);
  endproperty
  a_rdy: assert property (p_rdy) else $error("init ready outside init");

  c_sum:   cover property (@(posedge clock) hour_inc_pulse);
  c_sync:  cover property (@(posedge clock) sts_reg[STS_SYNCED]);
  c_rdy:   cover property (@(posedge clock) sts_reg[STS_INIT_RDY]);
  c_irq:   cover property (@(posedge clock) irq);

endmodule

/* File: testbench/tb_top.sv */
/*
  tb_top: self-checking bench for rtccs_top, avalon-mm tasks plus
  sequences of register calls, pin checks and strobe counting.
  assumes: rtccs_pkg compiled first, design built with small dividers 3/3.
*/
`timescale 1ns/1ps
module tb_top
  import rtccs_pkg::*;
();
  // clock and reset
  logic        clock;
  logic        rst;
  logic        clk_en;
  // avalon-mm
  logic [7:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  // calendar side and pins
  logic [7:0]  year_field;
  logic        alarm_a_match_flag;
  logic        wakeup_expired_flag;
  logic        alarm_value_change;
  logic        calibration_pin;
  logic        alarm_pin;
  logic        hour_inc_pulse;
  logic        hour_dec_pulse;
  logic        irq;
  // bench state
  int          n_fail;
  int          comparisons;
  int          n_inc;
  int          n_dec;
  int          c0;
  int          c1;
  logic        irq_a;

  rtccs_top #(.ASYNC_DIV(3), .SYNC_DIV(3)) uut (
    .clock(clock), .rst(rst), .clk_en(clk_en),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .year_field(year_field), .alarm_a_match_flag(alarm_a_match_flag),
    .wakeup_expired_flag(wakeup_expired_flag), .alarm_value_change(alarm_value_change),
    .calibration_pin(calibration_pin), .alarm_pin(alarm_pin),
    .hour_inc_pulse(hour_inc_pulse), .hour_dec_pulse(hour_dec_pulse), .irq(irq)
  );

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // strobes are one cycle wide, so count them at every edge
  always @(posedge clock) begin
    if (hour_inc_pulse === 1'b1) n_inc++;
    if (hour_dec_pulse === 1'b1) n_dec++;
  end

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clock);
    address    <= a;
    writedata  <= d;
    byteenable <= be;
    read       <= rd;
    write      <= !rd;
    do begin
      @(posedge clock);
      k++;
    end while (waitrequest !== 1'b0 && k < 100);
    if (k >= 100) n_fail++;
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, 4'hf, q);
  endtask

  task automatic ctl(input logic [31:0] d);
    w(OFS_CTRL, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b1, a, 32'h0, 4'hf, q);
    check(q & m, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic cnt_tog(output int n);
    logic p;
    n = 0;
    p = calibration_pin;
    repeat (256) begin
      @(posedge clock);
      if (calibration_pin !== p) n++;
      p = calibration_pin;
    end
  endtask

  initial begin
    #100000;
    n_fail++;
    wrap_up();
  end

  initial begin
    n_fail = 0; comparisons = 0; n_inc = 0; n_dec = 0;
    rst = 1'b1; clk_en = 1'b1; address = 8'h00; read = 1'b0; write = 1'b0;
    writedata = 32'h0; byteenable = 4'hf; year_field = 8'h00;
    alarm_a_match_flag = 1'b0; wakeup_expired_flag = 1'b0; alarm_value_change = 1'b0;
    idle(10);
    rst <= 1'b0;
    idle(8);
    rd_chk(OFS_CTRL, 32'hffff_ffff, 32'h0);
    rd_chk(OFS_STS, 32'hffff_ff1e, 32'h0000_0004);
    // locked: writes must not land
    w(OFS_STS, 32'h0000_0080);
    rd_chk(OFS_STS, 32'h0000_0080, 32'h0);
    w(OFS_WPROT, {24'h0, WP_KEY1});
    w(OFS_WPROT, {24'h0, WP_KEY2});
    rd_chk(8'h80, 32'hffff_ffff, 32'h0);
    // only byte lane 2 written; summer/winter bits read back zero
    bus(1'b0, OFS_CTRL, 32'h00fc_0520, 4'h4, c0[31:0]);
    rd_chk(OFS_CTRL, 32'hffff_ffff, 32'h00fc_0000);
    ctl(32'hff00_0000);
    rd_chk(OFS_CTRL, 32'hffff_ffff, 32'h0);
    year_field <= 8'h21;
    idle(4);
    rd_chk(OFS_STS, 32'h0000_0010, 32'h0000_0010);
    ctl(32'h0000_0400);
    idle(4);
    rd_chk(OFS_STS, 32'h0000_0004, 32'h0);
    ctl(32'h0);
    idle(4);
    rd_chk(OFS_STS, 32'h0000_0004, 32'h0000_0004);
    @(posedge clock) alarm_value_change <= 1'b1;
    @(posedge clock) alarm_value_change <= 1'b0;
    idle(3);
    rd_chk(OFS_STS, 32'h0000_0001, 32'h0000_0001);
    w(OFS_STS, 32'h0000_0080);
    idle(4);
    rd_chk(OFS_STS, 32'h0000_00e1, 32'h0000_00c0);
    w(OFS_STS, 32'h0);
    idle(4);
    rd_chk(OFS_STS, 32'h0000_00c0, 32'h0);
    rd_chk(OFS_STS, 32'h0000_0001, 32'h0);
    // alarm enabled: a value change must not mark it
    ctl(32'h0000_0100);
    @(posedge clock) alarm_value_change <= 1'b1;
    @(posedge clock) alarm_value_change <= 1'b0;
    idle(3);
    rd_chk(OFS_STS, 32'h0000_0001, 32'h0);
    ctl(32'h0);
    @(posedge clock) alarm_value_change <= 1'b1;
    @(posedge clock) alarm_value_change <= 1'b0;
    idle(3);
    rd_chk(OFS_STS, 32'h0000_0001, 32'h0000_0001);
    idle(6);
    rd_chk(OFS_STS, 32'h0000_0020, 32'h0000_0020);
    ctl(32'h0000_0020);
    idle(4);
    rd_chk(OFS_STS, 32'h0000_0020, 32'h0);
    // with bypass on no sync event re-arms, so the clear is visible
    w(OFS_IRQ_STS, 32'h0000_000f);
    rd_chk(OFS_IRQ_STS, 32'h0000_000f, 32'h0);
    check({31'h0, irq}, 32'h0);
    ctl(32'h0);
    idle(6);
    w(OFS_IRQ_MASK, 32'h0000_0001);
    idle(3);
    irq_a = irq;
    w(OFS_IRQ_MASK, 32'h0);
    idle(3);
    check({30'h0, irq_a, irq}, 32'h2);
    ctl(32'h0000_0020);
    w(OFS_IRQ_STS, 32'h0000_000f);
    idle(3);
    check({31'h0, irq}, 32'h0);
    w(OFS_SHIFT, 32'h0000_0001);
    rd_chk(OFS_STS, 32'h0000_0008, 32'h0000_0008);
    idle(8);
    rd_chk(OFS_IRQ_STS, 32'h0000_0008, 32'h0000_0008);
    rd_chk(OFS_STS, 32'h0000_0008, 32'h0);
    w(OFS_STS, 32'h0000_0008);
    rd_chk(OFS_STS, 32'h0000_0008, 32'h0);
    // hour adjust, live view through bypass
    rd_chk(OFS_CAL_VIEW, 32'h0000_00ff, 32'h0);
    ctl(32'h0002_0020);
    idle(64);
    check(n_dec, 32'h0);
    rd_chk(OFS_CAL_VIEW, 32'h0000_00ff, 32'h0);
    ctl(32'h0001_0020);
    idle(64);
    check(n_inc, 32'h1);
    rd_chk(OFS_CAL_VIEW, 32'h0000_00ff, 32'h1);
    rd_chk(OFS_CTRL, 32'h0003_0000, 32'h0);
    ctl(32'h0002_0020);
    idle(64);
    check(n_dec, 32'h1);
    rd_chk(OFS_CAL_VIEW, 32'h0000_00ff, 32'h0);
    // alarm pin: both routes, both polarities, flag set and clear
    for (int r = 0; r < 2; r++) begin
      for (int p = 0; p < 2; p++) begin
        for (int a = 0; a < 2; a++) begin
          ctl({8'h00, 1'b0, (r == 1) ? ROUTE_WAKE : ROUTE_ALARM, p[0], 20'h00020});
          alarm_a_match_flag  <= (r == 0) ? a[0] : !a[0];
          wakeup_expired_flag <= (r == 1) ? a[0] : !a[0];
          idle(4);
          check({31'h0, alarm_pin}, {31'h0, a[0] ^ p[0]});
        end
      end
    end
    alarm_a_match_flag  <= 1'b1;
    wakeup_expired_flag <= 1'b1;
    ctl({8'h00, 1'b0, ROUTE_OFF, 1'b0, 20'h00020});
    idle(4);
    check({31'h0, alarm_pin}, 32'h0);
    cnt_tog(c0);
    check(c0, 32'h0);
    check({31'h0, calibration_pin}, 32'h0);
    ctl(32'h0080_0020);
    idle(4);
    cnt_tog(c0);
    ctl(32'h0088_0020);
    idle(4);
    cnt_tog(c1);
    // exact rates depend on the reduced dividers, so only order them
    check({31'h0, c0 > c1 && c1 > 0}, 32'h1);
    // clock enable low: the running tap must freeze
    @(posedge clock) clk_en <= 1'b0;
    idle(2);
    cnt_tog(c1);
    check(c1, 32'h0);
    @(posedge clock) clk_en <= 1'b1;
    wrap_up();
  end
endmodule
